/* File: rtl/ipa_regs.sv */
// startup flag, power-profile and alarm register group behind the serial configuration port
// assumes alarm sources and the initialisation sequencer run on ref_clk; no extra synchronisation
//
// Contract
// - startup-complete bit reads 1 once initialisation is finished, else 0
// - profile b: low power 0x06, high performance 0x0F, reset 0x0F
// - profile c: low power 0x00, high performance 0x04, reset 0x04
// - profile d: low power 0x14, high performance 0x1B, reset 0x1B
// - summary alarm reads 1 when any unmasked flag is set
// - masked flags are left out of the summary alarm
// - summary alarm drives the status pin when selected
// - alarm flags reset to 0x3F; writes clear, never store
// - flag positions: underflow 5, pll 4, link 3, realign 2, clock 0
// - pll flag set while the serializer pll is unlocked, sticky
// - writing 1 clears that flag; writing 0 leaves it alone
// - alarm mask resets to 0x3F, masking every source

`timescale 1ns/100ps

module ipa_regs (
   input  wire logic                         ref_clk,            // 20 MHz configuration clock
   input  wire logic                         rstn,               // asynchronous reset, active low
   input  wire logic                         soft_reset,         // one-cycle soft reset pulse
   input  wire logic                         sclk,               // serial clock pin
   input  wire logic                         csb_n,              // chip select pin
   input  wire logic                         sdi,                // serial data in pin
   output logic                              sdo,                // serial data out
   output logic                              sdo_oe,             // high while sdo driven
   input  wire logic                         init_done_in,       // initialisation sequence finished
   input  ipa_pkg::ipa_alarm_src_t           alarm_src,          // alarm events and pll unlock level
   input  wire logic                         status_sel_alarm,   // status pin shows the summary alarm
   input  wire logic                         cal_status_in,      // status shown when not selecting alarm
   output logic                              status_output_pin,  // status pin level
   output logic [ipa_pkg::DATA_W-1:0]        power_field_b,      // profile b code
   output logic [ipa_pkg::DATA_W-1:0]        power_field_c,      // profile c code
   output logic [ipa_pkg::DATA_W-1:0]        power_field_d,      // profile d code
   output logic                              low_power_mode      // all three profiles hold low-power codes
);

   typedef struct packed {
      logic                              init_done;
      logic [ipa_pkg::DATA_W-1:0]        pwr_b;
      logic [ipa_pkg::DATA_W-1:0]        pwr_c;
      logic [ipa_pkg::DATA_W-1:0]        pwr_d;
      logic [ipa_pkg::FLAG_W-1:0]        flags;
      logic [ipa_pkg::FLAG_W-1:0]        mask;
      logic                              summary;
      logic                              status_pin;
      logic                              low_power;
   } ipa_regs_st_t;

   ipa_regs_st_t                st_r;
   ipa_regs_st_t                st_nxt;
   ipa_pkg::ipa_req_t           req;
   logic [ipa_pkg::DATA_W-1:0]  rdata;
   logic [ipa_pkg::FLAG_W-1:0]  flag_set;
   logic [ipa_pkg::FLAG_W-1:0]  flag_clr;
   logic [ipa_pkg::FLAG_W-1:0]  flags_now;

   function automatic logic hit(input logic [ipa_pkg::ADDR_W-1:0] a, input logic [ipa_pkg::ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // ----------------------------------------------------------------
   // serial port
   // ----------------------------------------------------------------
   ipa_spi_port u_port (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .sclk    (sclk),
      .csb_n   (csb_n),
      .sdi     (sdi),
      .sdo     (sdo),
      .sdo_oe  (sdo_oe),
      .req     (req),
      .rdata   (rdata)
   );

   // ----------------------------------------------------------------
   // read mux; unmapped addresses and reserved bits read zero
   // ----------------------------------------------------------------
   always_comb begin
      rdata = 8'h00;
      if (hit(req.addr, ipa_pkg::OFS_STARTUP_PROGRESS)) rdata = {7'h00, st_r.init_done};
      if (hit(req.addr, ipa_pkg::OFS_POWER_PROFILE_B))  rdata = st_r.pwr_b;
      if (hit(req.addr, ipa_pkg::OFS_POWER_PROFILE_C))  rdata = st_r.pwr_c;
      if (hit(req.addr, ipa_pkg::OFS_POWER_PROFILE_D))  rdata = st_r.pwr_d;
      if (hit(req.addr, ipa_pkg::OFS_ALARM_SUMMARY))    rdata = {7'h00, st_r.summary};
      if (hit(req.addr, ipa_pkg::OFS_ALARM_FLAGS))      rdata = {2'h0, st_r.flags};
      if (hit(req.addr, ipa_pkg::OFS_ALARM_MASK))       rdata = {2'h0, st_r.mask};
   end

   // ----------------------------------------------------------------
   // alarm set and clear
   // ----------------------------------------------------------------
   always_comb begin
      flag_set                         = '0;
      flag_set[ipa_pkg::BIT_UNDERFLOW] = alarm_src.underflow;
      flag_set[ipa_pkg::BIT_SER_PLL]   = alarm_src.ser_pll_unlocked;
      flag_set[ipa_pkg::BIT_LINK]      = alarm_src.link_evt;
      flag_set[ipa_pkg::BIT_REALIGN]   = alarm_src.realign_evt;
      flag_set[ipa_pkg::BIT_CLOCK]     = alarm_src.clock_evt;
      flag_clr = '0;
      if (req.wr && hit(req.addr, ipa_pkg::OFS_ALARM_FLAGS)) begin
         flag_clr = req.wdata[ipa_pkg::FLAG_W-1:0];
      end
      // a source active in the clearing cycle keeps its flag set
      flags_now = (st_r.flags & ~flag_clr) | flag_set;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt           = st_r;
      st_nxt.init_done = init_done_in;
      st_nxt.flags     = flags_now;
      if (req.wr) begin
         // read-only offsets have no write path
         if (hit(req.addr, ipa_pkg::OFS_POWER_PROFILE_B)) st_nxt.pwr_b = req.wdata;
         if (hit(req.addr, ipa_pkg::OFS_POWER_PROFILE_C)) st_nxt.pwr_c = req.wdata;
         if (hit(req.addr, ipa_pkg::OFS_POWER_PROFILE_D)) st_nxt.pwr_d = req.wdata;
         if (hit(req.addr, ipa_pkg::OFS_ALARM_MASK)) begin
            st_nxt.mask = req.wdata[ipa_pkg::FLAG_W-1:0];
         end
      end
      // summary follows the flags one cycle later
      st_nxt.summary    = |(st_r.flags & ~st_r.mask);
      st_nxt.status_pin = status_sel_alarm ? st_r.summary : cal_status_in;
      st_nxt.low_power  = (st_r.pwr_b == ipa_pkg::LP_CODE_B) && (st_r.pwr_c == ipa_pkg::LP_CODE_C)
                          && (st_r.pwr_d == ipa_pkg::LP_CODE_D);
      if (soft_reset) begin
         st_nxt.pwr_b = ipa_pkg::RST_POWER_B;
         st_nxt.pwr_c = ipa_pkg::RST_POWER_C;
         st_nxt.pwr_d = ipa_pkg::RST_POWER_D;
         st_nxt.flags = ipa_pkg::RST_FLAGS;
         st_nxt.mask  = ipa_pkg::RST_MASK;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_r       <= '0;
         st_r.pwr_b <= ipa_pkg::RST_POWER_B;
         st_r.pwr_c <= ipa_pkg::RST_POWER_C;
         st_r.pwr_d <= ipa_pkg::RST_POWER_D;
         st_r.flags <= ipa_pkg::RST_FLAGS;
         st_r.mask  <= ipa_pkg::RST_MASK;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign status_output_pin = st_r.status_pin;
   assign power_field_b     = st_r.pwr_b;
   assign power_field_c     = st_r.pwr_c;
   assign power_field_d     = st_r.pwr_d;
   assign low_power_mode    = st_r.low_power;

endmodule : ipa_regs

/* File: pkg/ipa_pkg.sv */
// constants, types and register map of the startup, power-profile and alarm register group
// assumes one 20 MHz configuration clock and a serial configuration port sampled on that clock

package ipa_pkg;

   // ----------------------------------------------------------------
   // serial frame layout
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W      = 15;
   localparam int unsigned DATA_W      = 8;
   localparam logic [4:0]  ADDR_BITS   = 5'h10;   // read flag plus address
   localparam logic [4:0]  FRAME_BITS  = 5'h18;   // whole frame with data
   localparam int unsigned SYNC_STAGES = 3;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_STARTUP_PROGRESS = 15'h0270;
   localparam logic [ADDR_W-1:0] OFS_POWER_PROFILE_B  = 15'h029A;
   localparam logic [ADDR_W-1:0] OFS_POWER_PROFILE_C  = 15'h029B;
   localparam logic [ADDR_W-1:0] OFS_POWER_PROFILE_D  = 15'h029C;
   localparam logic [ADDR_W-1:0] OFS_ALARM_SUMMARY    = 15'h02C0;
   localparam logic [ADDR_W-1:0] OFS_ALARM_FLAGS      = 15'h02C1;
   localparam logic [ADDR_W-1:0] OFS_ALARM_MASK       = 15'h02C2;

   // ----------------------------------------------------------------
   // reset values and mode codes
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] RST_POWER_B   = 8'h0F;
   localparam logic [DATA_W-1:0] RST_POWER_C   = 8'h04;
   localparam logic [DATA_W-1:0] RST_POWER_D   = 8'h1B;
   localparam logic [5:0]        RST_FLAGS     = 6'h3F;
   localparam logic [5:0]        RST_MASK      = 6'h3F;
   localparam logic [DATA_W-1:0] LP_CODE_B     = 8'h06;
   localparam logic [DATA_W-1:0] HP_CODE_B     = 8'h0F;
   localparam logic [DATA_W-1:0] LP_CODE_C     = 8'h00;
   localparam logic [DATA_W-1:0] HP_CODE_C     = 8'h04;
   localparam logic [DATA_W-1:0] LP_CODE_D     = 8'h14;
   localparam logic [DATA_W-1:0] HP_CODE_D     = 8'h1B;

   // ----------------------------------------------------------------
   // alarm flag bit positions
   // ----------------------------------------------------------------
   localparam int unsigned FLAG_W        = 6;
   localparam int unsigned BIT_UNDERFLOW = 5;
   localparam int unsigned BIT_SER_PLL   = 4;
   localparam int unsigned BIT_LINK      = 3;
   localparam int unsigned BIT_REALIGN   = 2;
   localparam int unsigned BIT_CLOCK     = 0;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SP_IDLE = 2'h0,
      SP_ADDR = 2'h1,
      SP_DATA = 2'h3
   } ipa_spi_state_t;

   typedef struct packed {
      logic              wr;      // one-cycle write strobe
      logic              rd;      // one-cycle read strobe
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ipa_req_t;

   typedef struct packed {
      logic underflow;
      logic ser_pll_unlocked;
      logic link_evt;
      logic realign_evt;
      logic clock_evt;
   } ipa_alarm_src_t;

endpackage : ipa_pkg

/* File: rtl/ipa_spi_port.sv */
// serial configuration port front end: synchronises the pins and turns frames into register requests
// assumes the serial clock is slow against ref_clk (at least ten ref_clk periods per serial clock period)

`timescale 1ns/100ps

module ipa_spi_port (
   input  wire logic                         ref_clk,  // 20 MHz configuration clock
   input  wire logic                         rstn,     // asynchronous reset, active low
   input  wire logic                         sclk,     // serial clock pin
   input  wire logic                         csb_n,    // chip select pin, active low
   input  wire logic                         sdi,      // serial data in pin
   output logic                              sdo,      // serial data out
   output logic                              sdo_oe,   // high while sdo is driven
   output ipa_pkg::ipa_req_t                 req,      // register request
   input  wire logic [ipa_pkg::DATA_W-1:0]   rdata     // read data for req.addr
);

   typedef struct packed {
      logic [ipa_pkg::SYNC_STAGES-1:0] sclk_s;
      logic [ipa_pkg::SYNC_STAGES-1:0] csb_s;
      logic [ipa_pkg::SYNC_STAGES-1:0] sdi_s;
      logic                            sclk_f;
      logic                            csb_f;
      logic                            sdi_f;
      ipa_pkg::ipa_spi_state_t         state;
      logic [4:0]                      cnt;
      logic [23:0]                     shift;
      logic [ipa_pkg::DATA_W-1:0]      tx;
      logic                            is_read;
      logic                            sdo;
      ipa_pkg::ipa_req_t               req;
   } ipa_spi_st_t;

   ipa_spi_st_t st_r;
   ipa_spi_st_t st_nxt;
   logic        rise;
   logic        fall;
   logic [4:0]  cnt_inc;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.req.wr = 1'b0;
      st_nxt.req.rd = 1'b0;
      st_nxt.sclk_s = {st_r.sclk_s[1:0], sclk};
      st_nxt.csb_s  = {st_r.csb_s[1:0], csb_n};
      st_nxt.sdi_s  = {st_r.sdi_s[1:0], sdi};
      // a level counts only once stages two and three agree
      if (st_r.sclk_s[1] == st_r.sclk_s[2]) st_nxt.sclk_f = st_r.sclk_s[2];
      if (st_r.csb_s[1] == st_r.csb_s[2])   st_nxt.csb_f  = st_r.csb_s[2];
      if (st_r.sdi_s[1] == st_r.sdi_s[2])   st_nxt.sdi_f  = st_r.sdi_s[2];
      rise    = st_nxt.sclk_f & ~st_r.sclk_f;
      fall    = ~st_nxt.sclk_f & st_r.sclk_f;
      cnt_inc = st_r.cnt + 5'h01;
      if (st_nxt.csb_f) begin
         // deselect aborts any partial frame; nothing is written
         st_nxt.state = ipa_pkg::SP_IDLE;
         st_nxt.cnt   = 5'h00;
      end else begin
         case (st_r.state)
            ipa_pkg::SP_IDLE: begin
               st_nxt.state = ipa_pkg::SP_ADDR;
               st_nxt.cnt   = 5'h00;
            end
            ipa_pkg::SP_ADDR: begin
               if (rise) begin
                  st_nxt.shift = {st_r.shift[22:0], st_nxt.sdi_f};
                  st_nxt.cnt   = cnt_inc;
                  if (cnt_inc == ipa_pkg::ADDR_BITS) begin
                     st_nxt.state    = ipa_pkg::SP_DATA;
                     st_nxt.is_read  = st_r.shift[14];
                     st_nxt.req.addr = {st_r.shift[13:0], st_nxt.sdi_f};
                     st_nxt.req.rd   = st_r.shift[14];
                  end
               end
            end
            ipa_pkg::SP_DATA: begin
               if (st_r.req.rd) st_nxt.tx = rdata;
               if (fall && st_r.is_read) begin
                  st_nxt.sdo = st_r.tx[7];
                  st_nxt.tx  = {st_r.tx[6:0], 1'b0};
               end
               if (rise) begin
                  st_nxt.shift = {st_r.shift[22:0], st_nxt.sdi_f};
                  st_nxt.cnt   = cnt_inc;
                  if (cnt_inc == ipa_pkg::FRAME_BITS) begin
                     st_nxt.state     = ipa_pkg::SP_IDLE;
                     st_nxt.req.wdata = {st_r.shift[6:0], st_nxt.sdi_f};
                     st_nxt.req.wr    = ~st_r.is_read;
                  end
               end
            end
            default: st_nxt.state = ipa_pkg::SP_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_r        <= '0;
         st_r.sclk_f <= 1'b0;
         st_r.csb_f  <= 1'b1;
         st_r.csb_s  <= 3'h7;
         st_r.state  <= ipa_pkg::SP_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign req    = st_r.req;
   assign sdo    = st_r.sdo;
   assign sdo_oe = ~st_r.csb_f & st_r.is_read & (st_r.state == ipa_pkg::SP_DATA);

endmodule : ipa_spi_port

/* File: bench/ipa_regs_properties.sv */
// checker for the startup, power-profile and alarm register group
// assumes it is bound to ipa_regs and sees only that module's ports
`timescale 1ns/100ps
module ipa_regs_properties (
   input wire logic                       ref_clk,           // configuration clock
   input wire logic                       rstn,              // async reset, active low
   input wire logic                       soft_reset,        // soft reset pulse
   input wire logic                       csb_n,             // chip select pin
   input wire logic                       status_sel_alarm,  // status pin select
   input wire logic                       cal_status_in,     // alternate status level
   input wire logic                       sdo_oe,            // sdo drive enable
   input wire logic                       status_output_pin, // status pin
   input wire logic [ipa_pkg::DATA_W-1:0] power_field_b,     // profile b
   input wire logic [ipa_pkg::DATA_W-1:0] power_field_c,     // profile c
   input wire logic [ipa_pkg::DATA_W-1:0] power_field_d,     // profile d
   input wire logic                       low_power_mode     // low-power flag
);
   logic [3:0] idle_r;  // cycles with chip select high, saturating
   logic [1:0] up_r;    // cycles since reset release, saturating
   wire        lp_codes = power_field_b == ipa_pkg::LP_CODE_B && power_field_c == ipa_pkg::LP_CODE_C &&
                          power_field_d == ipa_pkg::LP_CODE_D;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         idle_r <= 4'h0;
         up_r   <= 2'h0;
      end else begin
         idle_r <= csb_n ? ((idle_r == 4'hF) ? idle_r : idle_r + 4'h1) : 4'h0;
         up_r   <= (up_r == 2'h3) ? up_r : up_r + 2'h1;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   // ----------------------------------------------------------------
   // profile defaults, then the derived mode flag a cycle later
   // ----------------------------------------------------------------
   sequence s_hp;
      power_field_b == ipa_pkg::HP_CODE_B && power_field_c == ipa_pkg::HP_CODE_C &&
      power_field_d == ipa_pkg::HP_CODE_D;
   endsequence
   chk_rst_defaults: assert property ($rose(rstn) |-> s_hp ##0 (!low_power_mode && !sdo_oe))
      else $error("profile defaults missing after reset");
   chk_soft_defaults: assert property (soft_reset |=> s_hp ##1 !low_power_mode)
      else $error("soft reset did not restore profiles");
   chk_lp_set: assert property (lp_codes |=> low_power_mode)
      else $error("low power flag missing");
   chk_lp_clear: assert property (!lp_codes |=> !low_power_mode)
      else $error("low power flag without low power codes");
   chk_status_cal: assert property (up_r == 2'h3 && !status_sel_alarm && !$past(status_sel_alarm)
      |-> status_output_pin == $past(cal_status_in)) else $error("status pin ignores its select");
   chk_fields_idle: assert property (idle_r > 4'h3 && !$past(soft_reset)
      |-> $stable(power_field_b) && $stable(power_field_c) && $stable(power_field_d))
      else $error("profile changed outside a frame");
   chk_oe_idle: assert property (idle_r > 4'h7 |-> !sdo_oe)
      else $error("sdo driven while deselected");
   chk_oe_frame: assert property ($rose(sdo_oe) |-> !csb_n && !$past(csb_n, 8))
      else $error("sdo enabled outside a read");
   chk_oe_span: assert property ($rose(sdo_oe) |-> sdo_oe [*8])
      else $error("sdo enable too short for a data byte");
endmodule : ipa_regs_properties

/* File: bench/ipa_spi_host.sv */
// serial configuration host model: frames register reads and writes on the pins
// assumes the device samples the pins on ref_clk; half sets each sclk phase length
`timescale 1ns/100ps
module ipa_spi_host (
   input  wire logic       ref_clk, // configuration clock
   input  wire logic [3:0] half,    // ref_clk cycles per sclk phase, at least 5
   output logic            sclk,    // serial clock, still outside frames
   output logic            csb_n,   // chip select, active low
   output logic            sdi,     // serial data to the device
   input  wire logic       sdo,     // serial data from the device
   input  wire logic       sdo_oe   // device drives sdo
);
   initial begin
      sclk  = 1'b0;
      csb_n = 1'b1;
      sdi   = 1'b0;
   end
   // ----------------------------------------------------------------
   // one frame: read flag, 15-bit address, data byte, msb first
   // ----------------------------------------------------------------
   task automatic xfer(input logic rd, input logic [ipa_pkg::ADDR_W-1:0] a,
                       input logic [ipa_pkg::DATA_W-1:0] wd, output logic [ipa_pkg::DATA_W-1:0] q);
      logic [23:0] fr;
      int          i;
      fr = {rd, a, wd};
      q  = '0;
      @(posedge ref_clk);
      csb_n <= 1'b0;
      sdi   <= fr[23];
      repeat (half) @(posedge ref_clk);
      for (i = 23; i >= 0; i--) begin
         sclk <= 1'b1;
         // a bit counts only while the device really drives the line
         if (rd && i < 8) q[i] = sdo_oe ? sdo : 1'bx;
         repeat (half) @(posedge ref_clk);
         sclk <= 1'b0;
         if (i > 0) sdi <= fr[i-1];
         repeat (half) @(posedge ref_clk);
      end
      csb_n <= 1'b1;
      sdi   <= ~sdi;  // idle data line never keeps the last bit
      repeat (8) @(posedge ref_clk);
   endtask : xfer
endmodule : ipa_spi_host

/* File: bench/tb_ipa_regs.sv */
// self-checking bench for ipa_regs driven through the serial host model
// assumes the package, design, checker and host model are compiled first
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_ipa_regs;
   typedef struct packed {
      logic [ipa_pkg::ADDR_W-1:0] addr;
      logic [ipa_pkg::DATA_W-1:0] wdata;
      logic [ipa_pkg::DATA_W-1:0] exp;
   } ipa_row_t;
   logic                       ref_clk, rstn, soft_reset, init_done_in, status_sel_alarm, cal_status_in;
   logic                       sclk, csb_n, sdi, sdo, sdo_oe, status_output_pin, low_power_mode;
   logic [3:0]                 half;
   logic [ipa_pkg::DATA_W-1:0] power_field_b, power_field_c, power_field_d, v;
   ipa_pkg::ipa_alarm_src_t    alarm_src;
   int                         bad_count = 0;
   int                         n_compared = 0;
   int                         cyc = 0;
   int                         k;
   localparam logic [24:0] LP_ALL = {ipa_pkg::LP_CODE_B, ipa_pkg::LP_CODE_C, ipa_pkg::LP_CODE_D, 1'b1};
   localparam logic [24:0] HP_ALL = {ipa_pkg::HP_CODE_B, ipa_pkg::HP_CODE_C, ipa_pkg::HP_CODE_D, 1'b0};
   logic [ipa_pkg::DATA_W-1:0] bit_of [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
   ipa_row_t                   rows [5] = '{
      '{ipa_pkg::OFS_ALARM_FLAGS, 8'h3F, 8'h00},
      '{ipa_pkg::OFS_STARTUP_PROGRESS, 8'hFF, 8'h01},
      '{ipa_pkg::OFS_ALARM_SUMMARY, 8'hFF, 8'h00},
      '{ipa_pkg::OFS_ALARM_MASK, 8'hFF, 8'h3F},
      '{15'h0300, 8'h55, 8'h00}};
   ipa_regs i_ipa_regs (.ref_clk(ref_clk), .rstn(rstn), .soft_reset(soft_reset), .sclk(sclk), .csb_n(csb_n),
      .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .init_done_in(init_done_in), .alarm_src(alarm_src),
      .status_sel_alarm(status_sel_alarm), .cal_status_in(cal_status_in), .status_output_pin(status_output_pin),
      .power_field_b(power_field_b), .power_field_c(power_field_c), .power_field_d(power_field_d),
      .low_power_mode(low_power_mode));
   ipa_spi_host i_ipa_spi_host (.ref_clk(ref_clk), .half(half), .sclk(sclk), .csb_n(csb_n), .sdi(sdi),
      .sdo(sdo), .sdo_oe(sdo_oe));
   // ----------------------------------------------------------------
   // register access and closing
   // ----------------------------------------------------------------
   task automatic reg_wr(input logic [ipa_pkg::ADDR_W-1:0] a, input logic [ipa_pkg::DATA_W-1:0] d);
      logic [ipa_pkg::DATA_W-1:0] q;
      i_ipa_spi_host.xfer(1'b0, a, d, q);
   endtask : reg_wr
   task automatic reg_rd(input logic [ipa_pkg::ADDR_W-1:0] a, output logic [ipa_pkg::DATA_W-1:0] q);
      i_ipa_spi_host.xfer(1'b1, a, 8'h00, q);
      @(negedge ref_clk);
   endtask : reg_rd
   // all three codes from one listed mode, written in three successive frames
   task automatic set_mode(input logic lp);
      reg_wr(ipa_pkg::OFS_POWER_PROFILE_B, lp ? ipa_pkg::LP_CODE_B : ipa_pkg::HP_CODE_B);
      reg_wr(ipa_pkg::OFS_POWER_PROFILE_C, lp ? ipa_pkg::LP_CODE_C : ipa_pkg::HP_CODE_C);
      reg_wr(ipa_pkg::OFS_POWER_PROFILE_D, lp ? ipa_pkg::LP_CODE_D : ipa_pkg::HP_CODE_D);
      @(negedge ref_clk);
   endtask : set_mode
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         bad_count++;
         finish_test();
      end
   end
   initial begin
      {rstn, soft_reset, init_done_in, status_sel_alarm, cal_status_in} = 5'h00;
      alarm_src = '0;
      half = 4'h6;
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      reg_rd(ipa_pkg::OFS_STARTUP_PROGRESS, v);
      `CHK(v, 8'h00)
      @(posedge ref_clk) init_done_in <= 1'b1;
      reg_rd(ipa_pkg::OFS_STARTUP_PROGRESS, v);
      `CHK(v, 8'h01)
      reg_rd(ipa_pkg::OFS_ALARM_FLAGS, v);
      `CHK(v, 8'h3F)
      reg_rd(ipa_pkg::OFS_ALARM_MASK, v);
      `CHK(v, 8'h3F)
      for (k = 0; k < 5; k++) begin
         reg_wr(rows[k].addr, rows[k].wdata);
         reg_rd(rows[k].addr, v);
         `CHK(v, rows[k].exp)
      end
      for (k = 0; k < 2; k++) begin
         half = (k == 0) ? 4'h6 : 4'hB;
         set_mode(k == 0);
         `CHK({power_field_b, power_field_c, power_field_d, low_power_mode}, (k == 0) ? LP_ALL : HP_ALL)
      end
      for (k = 0; k < 5; k++) begin
         @(posedge ref_clk) alarm_src <= ipa_pkg::ipa_alarm_src_t'(5'h10 >> k);
         @(posedge ref_clk) alarm_src <= '0;
         reg_rd(ipa_pkg::OFS_ALARM_FLAGS, v);
         `CHK(v, bit_of[k])
         reg_wr(ipa_pkg::OFS_ALARM_FLAGS, 8'h00);
         reg_rd(ipa_pkg::OFS_ALARM_FLAGS, v);
         `CHK(v, bit_of[k])
         reg_wr(ipa_pkg::OFS_ALARM_FLAGS, bit_of[k]);
         reg_rd(ipa_pkg::OFS_ALARM_FLAGS, v);
         `CHK(v, 8'h00)
      end
      @(posedge ref_clk) alarm_src <= ipa_pkg::ipa_alarm_src_t'(5'h08);
      status_sel_alarm <= 1'b1;
      reg_wr(ipa_pkg::OFS_ALARM_FLAGS, 8'h10);
      reg_rd(ipa_pkg::OFS_ALARM_FLAGS, v);
      `CHK(v, 8'h10)
      reg_rd(ipa_pkg::OFS_ALARM_SUMMARY, v);
      `CHK({v, status_output_pin}, 9'h000)
      reg_wr(ipa_pkg::OFS_ALARM_MASK, 8'h2F);
      reg_rd(ipa_pkg::OFS_ALARM_SUMMARY, v);
      `CHK({v, status_output_pin}, 9'h003)
      @(posedge ref_clk) alarm_src <= '0;
      status_sel_alarm <= 1'b0;
      cal_status_in <= 1'b1;
      reg_rd(ipa_pkg::OFS_ALARM_FLAGS, v);
      `CHK(v, 8'h10)
      reg_wr(ipa_pkg::OFS_ALARM_FLAGS, 8'h10);
      @(posedge ref_clk) alarm_src <= ipa_pkg::ipa_alarm_src_t'(5'h04);
      @(posedge ref_clk) alarm_src <= '0;
      reg_rd(ipa_pkg::OFS_ALARM_SUMMARY, v);
      `CHK({v, status_output_pin}, 9'h001)
      set_mode(1'b1);
      @(posedge ref_clk) soft_reset <= 1'b1;
      @(posedge ref_clk) soft_reset <= 1'b0;
      reg_rd(ipa_pkg::OFS_ALARM_MASK, v);
      `CHK(v, 8'h3F)
      reg_rd(ipa_pkg::OFS_ALARM_FLAGS, v);
      `CHK(v, 8'h3F)
      `CHK({power_field_b, power_field_c, power_field_d}, HP_ALL[24:1])
      set_mode(1'b1);
      @(posedge ref_clk) rstn <= 1'b0;
      @(negedge ref_clk);
      `CHK({power_field_b, power_field_c, power_field_d, low_power_mode}, HP_ALL)
      @(posedge ref_clk) rstn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      reg_rd(ipa_pkg::OFS_STARTUP_PROGRESS, v);
      `CHK(v, 8'h01)
      finish_test();
   end
endmodule : tb_ipa_regs
bind ipa_regs ipa_regs_properties i_ipa_regs_properties (.ref_clk(ref_clk), .rstn(rstn), .soft_reset(soft_reset),
   .csb_n(csb_n), .status_sel_alarm(status_sel_alarm), .cal_status_in(cal_status_in), .sdo_oe(sdo_oe),
   .status_output_pin(status_output_pin), .power_field_b(power_field_b), .power_field_c(power_field_c),
   .power_field_d(power_field_d), .low_power_mode(low_power_mode));
